// ---- hw/cmit_pkg.sv ----
// Constants shared by the host register map and interrupt tree.
// Assumes a single 40 MHz core clock and a synchronous word-wide host port.
//
// How it works
// [R1] Select input low steers an access into the internal register half.
// [R2] Select input high steers an access into the external memory window.
// [R3] Five latched page bits give the upper external address, 32 pages.
// [R4] Every host access is a whole 16-bit word; there are no byte lanes.
// [R5] Word locations are decoded from host address bit 1 upward.
// [R6] A sticky status bit is set by its condition and stays set after it.
// [R7] Writing one clears a sticky bit only once its condition has gone.
// [R8] Writes to read-only registers change nothing.
// [R9] Write-only mode bits are written high by the host and read as zero.
// [R10] The TX, RX and cell modules have event status bits and matching masks.
// [R11] Interrupt needs a status bit, its mask bit and its module enable.
// [R12] Main status shows which module holds a pending alarm.
// [R13] The host never writes the reserved words; they keep reset values.
// [R14] Main control bits 0 to 4 enable the five modules, active high.
// [R15] Until soft reset release is high only host-interface words respond.
// [R16] Unmapped internal words read zero and ignore writes.
`default_nettype none

package cmit_pkg;

    // ====================================================================
    // Widths
    localparam int DW      = 16;
    localparam int AW      = 15;
    localparam int PAGE_W  = 5;
    localparam int EXT_AW  = AW + PAGE_W;
    localparam int NUM_MOD = 5;

    // ====================================================================
    // Byte offsets of the internal registers
    localparam logic [15:0] OFF_MAIN_CONTROL    = 16'h0000;
    localparam logic [15:0] OFF_MAIN_STATUS     = 16'h0002;
    localparam logic [15:0] OFF_RESERVED_A      = 16'h0010;
    localparam logic [15:0] OFF_RESERVED_B      = 16'h0012;
    localparam logic [15:0] OFF_PAGE_WINDOW     = 16'h0030;
    localparam logic [15:0] OFF_RESERVED_C      = 16'h0032;
    localparam logic [15:0] OFF_RESERVED_D      = 16'h0034;
    localparam logic [15:0] OFF_READ_PARITY     = 16'h0036;
    localparam logic [15:0] OFF_MEMORY_CONFIG   = 16'h0040;
    localparam logic [15:0] OFF_TX_SEG_CONTROL  = 16'h2000;
    localparam logic [15:0] OFF_TX_SEG_STATUS   = 16'h2002;
    localparam logic [15:0] OFF_RX_REASM_CTRL   = 16'h3000;
    localparam logic [15:0] OFF_RX_REASM_STATUS = 16'h3002;
    localparam logic [15:0] OFF_RX_MISC_ID      = 16'h3010;
    localparam logic [15:0] OFF_RX_MISC_COUNT   = 16'h3012;
    localparam logic [15:0] OFF_RX_UNDER_ID     = 16'h3020;
    localparam logic [15:0] OFF_RX_UNDER_COUNT  = 16'h3022;
    localparam logic [15:0] OFF_RX_OVER_ID      = 16'h3030;
    localparam logic [15:0] OFF_RX_OVER_COUNT   = 16'h3032;
    localparam logic [15:0] OFF_CELL_PORT_CTRL  = 16'h4000;
    localparam logic [15:0] OFF_CELL_PORT_STAT  = 16'h4002;
    localparam logic [15:0] HOST_IF_LIMIT       = 16'h2000;

    // ====================================================================
    // Plain configuration words kept in the word memory, in index order:
    // sched_a base/frame_end/end_ratio, sched_b, sched_c,
    // tx_ctrl_struct_base, tx_cell_fifo base/wr_ptr/rd_ptr,
    // path_channel_concat, path_id match/mask, channel_id match/mask,
    // path_id_timing.
    localparam int RAM_WORDS = 19;
    localparam int RAM_IW    = 5;
    localparam logic [15:0] RAM_OFFS [RAM_WORDS] = '{
        16'h2010, 16'h2012, 16'h2014, 16'h2020, 16'h2022, 16'h2024,
        16'h2030, 16'h2032, 16'h2034, 16'h2040, 16'h2050, 16'h2052,
        16'h2054, 16'h4010, 16'h4012, 16'h4014, 16'h4016, 16'h4018,
        16'h401A};

    // ====================================================================
    // Reset values and fields
    localparam logic [15:0] RST_MAIN_CONTROL  = 16'h0000;
    localparam logic [15:0] RST_RESERVED_A    = 16'h0000;
    localparam logic [15:0] RST_RESERVED_B    = 16'h0001;
    localparam logic [15:0] RST_RESERVED_C    = 16'h0000;
    localparam logic [15:0] RST_RESERVED_D    = 16'h0000;
    localparam logic [15:0] RST_PAGE_WINDOW   = 16'h0000;
    localparam logic [15:0] RST_MEMORY_CONFIG = 16'h0008;
    localparam logic [15:0] RST_ZERO          = 16'h0000;
    localparam logic [15:0] MEMORY_CONFIG_WO_MASK    = 16'hF000;
    localparam int MOD_TDM  = 0;
    localparam int MOD_TX   = 1;
    localparam int MOD_RX   = 2;
    localparam int MOD_CELL = 3;
    localparam int MOD_TIM  = 4;
    localparam int SOFT_RESET_RELEASE_BIT = 15;

    // ====================================================================
    // Host access sequencer
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_INT,
        ST_EXT,
        ST_ANS
    } cmit_state_e;

endpackage : cmit_pkg

`default_nettype wire

// ---- hw/cmit_word_ram.sv ----
// Small word memory for plain configuration registers.
// Assumes one write or read per cycle; read data come out of a register.
`default_nettype none
`timescale 1ns/1ps

module cmit_word_ram #(
    parameter int DW    = 16,
    parameter int DEPTH = 19,
    parameter int IW    = 5
) (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          we,
    input  wire logic [IW-1:0] idx,
    input  wire logic [DW-1:0] wdata,
    output var  logic [DW-1:0] rdata_q
);

    // ====================================================================
    // Storage
    logic [DW-1:0] mem [DEPTH];

    // Contents are not reset; software programs every word before use.
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[idx] <= wdata;
        end
    end

    // Registered read keeps the answer path short.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[idx];
        end
    end

endmodule : cmit_word_ram

`default_nettype wire

// ---- hw/cmit_sticky_bank.sv ----
// One module status register of sticky, write-one-to-clear event bits.
// Assumes the event conditions are levels synchronous to the core clock.
`default_nettype none
`timescale 1ns/1ps

module cmit_sticky_bank #(
    parameter int W = 16
) (
    input  wire logic         core_clk,
    input  wire logic         hold_clear,
    input  wire logic [W-1:0] cond,
    input  wire logic [W-1:0] w1c,
    output var  logic [W-1:0] status_q
);

    // ====================================================================
    // Clear only where the condition is gone; a live event always wins.
    logic [W-1:0] status_d;

    assign status_d = (status_q & ~(w1c & ~cond)) | cond; // [R6] [R7]

    // The bank is held empty while the owning module is in reset.
    always_ff @(posedge core_clk) begin
        if (hold_clear) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

endmodule : cmit_sticky_bank

`default_nettype wire

// ---- hw/cmit_regmap.sv ----
// Host register map, external memory window and interrupt tree.
// Assumes host strobes synchronous to core_clk and one access at a time.
`default_nettype none
`timescale 1ns/1ps

module cmit_regmap (
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Host word port.
    input  wire logic        host_req,
    input  wire logic        host_wr,
    input  wire logic [14:0] host_addr,
    input  wire logic        int_ext_space_select,
    input  wire logic [15:0] host_wdata,
    output var  logic [15:0] host_rdata,
    output var  logic        host_ack,
    output var  logic        host_busy,
    // External memory side.
    output var  logic        ext_req,
    output var  logic        ext_we,
    output var  logic [19:0] ext_addr,
    output var  logic [15:0] ext_wdata,
    input  wire logic [15:0] ext_rdata,
    input  wire logic        ext_ack,
    // Module events and state.
    input  wire logic [15:0] tx_events,
    input  wire logic [15:0] rx_events,
    input  wire logic [15:0] cell_events,
    input  wire logic        tdm_pending,
    input  wire logic        tim_pending,
    input  wire logic [15:0] rx_misc_id,
    input  wire logic [15:0] rx_misc_count,
    input  wire logic [15:0] rx_under_id,
    input  wire logic [15:0] rx_under_count,
    input  wire logic [15:0] rx_over_id,
    input  wire logic [15:0] rx_over_count,
    // Outputs to the rest of the chip.
    output var  logic        irq,
    output var  logic        soft_reset_release,
    output var  logic [15:0] aal5_wo_bits
);

    // ====================================================================
    // Sequencer state and registers
    cmit_pkg::cmit_state_e state_q;
    cmit_pkg::cmit_state_e state_d;

    logic [15:0] main_control_q;
    logic [4:0]  page_q;
    logic [15:0] memcfg_q;
    logic [15:0] tx_ctl_q;
    logic [15:0] rx_ctl_q;
    logic [15:0] cell_ctl_q;
    logic [15:0] parity_q;
    logic [15:0] rd_mux_q;
    logic        sel_ram_q;
    logic        ext_rd_q;
    logic [15:0] rdata_q;
    logic        irq_q;
    logic        ext_req_q;
    logic        ext_we_q;
    logic [19:0] ext_addr_q;
    logic [15:0] ext_wdata_q;

    // ====================================================================
    // Access decode
    logic [15:0] byte_addr;
    logic        take;
    logic        take_int;
    logic        take_ext;
    logic        reg_open;
    logic        int_wr;

    // Host address bit 1 is the lowest line, so bit 0 is always zero.
    assign byte_addr = {host_addr, 1'b0}; // [R5]
    assign take      = host_req && (state_q == cmit_pkg::ST_IDLE);
    assign take_int  = take && !int_ext_space_select; // [R1]
    assign take_ext  = take && int_ext_space_select; // [R2]

    // Before soft reset release only the host-interface block answers.
    assign reg_open = soft_reset_release ||
                      (byte_addr < cmit_pkg::HOST_IF_LIMIT); // [R15]
    // Whole-word writes only; there is no byte-enable path at all.
    assign int_wr   = take_int && host_wr && reg_open; // [R4]

    // Register hits.
    logic hit_mc;
    logic hit_ms;
    logic hit_ra;
    logic hit_rb;
    logic hit_pw;
    logic hit_rc;
    logic hit_rd;
    logic hit_rp;
    logic hit_mem;
    logic hit_txc;
    logic hit_txs;
    logic hit_rxc;
    logic hit_rxs;
    logic hit_rmi;
    logic hit_rmc;
    logic hit_rui;
    logic hit_ruc;
    logic hit_roi;
    logic hit_roc;
    logic hit_cpc;
    logic hit_cps;

    assign hit_mc  = byte_addr == cmit_pkg::OFF_MAIN_CONTROL;
    assign hit_ms  = byte_addr == cmit_pkg::OFF_MAIN_STATUS;
    assign hit_ra  = byte_addr == cmit_pkg::OFF_RESERVED_A;
    assign hit_rb  = byte_addr == cmit_pkg::OFF_RESERVED_B;
    assign hit_pw  = byte_addr == cmit_pkg::OFF_PAGE_WINDOW;
    assign hit_rc  = byte_addr == cmit_pkg::OFF_RESERVED_C;
    assign hit_rd  = byte_addr == cmit_pkg::OFF_RESERVED_D;
    assign hit_rp  = byte_addr == cmit_pkg::OFF_READ_PARITY;
    assign hit_mem = byte_addr == cmit_pkg::OFF_MEMORY_CONFIG;
    assign hit_txc = byte_addr == cmit_pkg::OFF_TX_SEG_CONTROL;
    assign hit_txs = byte_addr == cmit_pkg::OFF_TX_SEG_STATUS;
    assign hit_rxc = byte_addr == cmit_pkg::OFF_RX_REASM_CTRL;
    assign hit_rxs = byte_addr == cmit_pkg::OFF_RX_REASM_STATUS;
    assign hit_rmi = byte_addr == cmit_pkg::OFF_RX_MISC_ID;
    assign hit_rmc = byte_addr == cmit_pkg::OFF_RX_MISC_COUNT;
    assign hit_rui = byte_addr == cmit_pkg::OFF_RX_UNDER_ID;
    assign hit_ruc = byte_addr == cmit_pkg::OFF_RX_UNDER_COUNT;
    assign hit_roi = byte_addr == cmit_pkg::OFF_RX_OVER_ID;
    assign hit_roc = byte_addr == cmit_pkg::OFF_RX_OVER_COUNT;
    assign hit_cpc = byte_addr == cmit_pkg::OFF_CELL_PORT_CTRL;
    assign hit_cps = byte_addr == cmit_pkg::OFF_CELL_PORT_STAT;

    // ====================================================================
    // Word memory for the plain configuration words
    logic [cmit_pkg::RAM_WORDS-1:0] ram_match;
    logic [cmit_pkg::RAM_IW-1:0]    ram_idx;
    logic                           ram_hit;
    logic [15:0]                    ram_rdata;

    for (genvar i = 0; i < cmit_pkg::RAM_WORDS; i++) begin : g_ram_hit
        assign ram_match[i] = byte_addr == cmit_pkg::RAM_OFFS[i];
    end

    assign ram_hit = |ram_match;

    // Encode the one-hot match into a word index.
    always_comb begin
        ram_idx = '0;
        for (int j = 0; j < cmit_pkg::RAM_WORDS; j++) begin
            if (ram_match[j]) begin
                ram_idx = cmit_pkg::RAM_IW'(j);
            end
        end
    end

    cmit_word_ram #(
        .DW    (16),
        .DEPTH (cmit_pkg::RAM_WORDS),
        .IW    (cmit_pkg::RAM_IW)
    ) u_cfg_ram (
        .core_clk (core_clk),
        .rst      (rst),
        .we       (int_wr && ram_hit),
        .idx      (ram_idx),
        .wdata    (host_wdata),
        .rdata_q  (ram_rdata)
    );

    // ====================================================================
    // Sticky module status banks
    logic        bank_hold;
    logic [15:0] tx_status;
    logic [15:0] rx_status;
    logic [15:0] cell_status;
    logic [15:0] tx_w1c;
    logic [15:0] rx_w1c;
    logic [15:0] cell_w1c;

    // Module status stays cleared while soft reset still holds the core.
    assign bank_hold = rst || !soft_reset_release;
    assign tx_w1c    = (int_wr && hit_txs) ? host_wdata : '0; // [R7]
    assign rx_w1c    = (int_wr && hit_rxs) ? host_wdata : '0; // [R7]
    assign cell_w1c  = (int_wr && hit_cps) ? host_wdata : '0; // [R7]

    cmit_sticky_bank #(.W(16)) u_tx_bank (
        .core_clk   (core_clk),
        .hold_clear (bank_hold),
        .cond       (tx_events),
        .w1c        (tx_w1c),
        .status_q   (tx_status)
    );

    cmit_sticky_bank #(.W(16)) u_rx_bank (
        .core_clk   (core_clk),
        .hold_clear (bank_hold),
        .cond       (rx_events),
        .w1c        (rx_w1c),
        .status_q   (rx_status)
    );

    cmit_sticky_bank #(.W(16)) u_cell_bank (
        .core_clk   (core_clk),
        .hold_clear (bank_hold),
        .cond       (cell_events),
        .w1c        (cell_w1c),
        .status_q   (cell_status)
    );

    // ====================================================================
    // Interrupt tree
    logic [cmit_pkg::NUM_MOD-1:0] mod_pending;

    // TX, RX and cell are pending when an event bit meets its own mask bit; TDM and timer pending come straight in.
    assign mod_pending[cmit_pkg::MOD_TDM]  = tdm_pending; // [R10]
    assign mod_pending[cmit_pkg::MOD_TX]   = |(tx_status & tx_ctl_q); // [R10]
    assign mod_pending[cmit_pkg::MOD_RX]   = |(rx_status & rx_ctl_q); // [R10]
    assign mod_pending[cmit_pkg::MOD_CELL] =
        |(cell_status & cell_ctl_q); // [R10]
    assign mod_pending[cmit_pkg::MOD_TIM]  = tim_pending; // [R10]

    // Module enables sit in main control bits 0 to 4.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(mod_pending &
                       main_control_q[cmit_pkg::NUM_MOD-1:0]); // [R11] [R14]
        end
    end

    // ====================================================================
    // Read data selection
    logic [15:0] rd_mux;
    logic [15:0] main_status;

    assign main_status = {11'h000, mod_pending}; // [R12]

    // Reserved words read their reset values; unmapped words read zero.
    always_comb begin
        rd_mux = cmit_pkg::RST_ZERO; // [R16]
        if (!reg_open) begin
            rd_mux = cmit_pkg::RST_ZERO; // [R15]
        end else if (hit_mc) begin
            rd_mux = main_control_q;
        end else if (hit_ms) begin
            rd_mux = main_status; // [R12]
        end else if (hit_ra) begin
            rd_mux = cmit_pkg::RST_RESERVED_A; // [R13]
        end else if (hit_rb) begin
            rd_mux = cmit_pkg::RST_RESERVED_B; // [R13]
        end else if (hit_rc) begin
            rd_mux = cmit_pkg::RST_RESERVED_C; // [R13]
        end else if (hit_rd) begin
            rd_mux = cmit_pkg::RST_RESERVED_D; // [R13]
        end else if (hit_pw) begin
            rd_mux = {11'h000, page_q};
        end else if (hit_rp) begin
            rd_mux = parity_q;
        end else if (hit_mem) begin
            rd_mux = memcfg_q & ~cmit_pkg::MEMORY_CONFIG_WO_MASK; // [R9]
        end else if (hit_txc) begin
            rd_mux = tx_ctl_q;
        end else if (hit_txs) begin
            rd_mux = tx_status;
        end else if (hit_rxc) begin
            rd_mux = rx_ctl_q;
        end else if (hit_rxs) begin
            rd_mux = rx_status;
        end else if (hit_rmi) begin
            rd_mux = rx_misc_id;
        end else if (hit_rmc) begin
            rd_mux = rx_misc_count;
        end else if (hit_rui) begin
            rd_mux = rx_under_id;
        end else if (hit_ruc) begin
            rd_mux = rx_under_count;
        end else if (hit_roi) begin
            rd_mux = rx_over_id;
        end else if (hit_roc) begin
            rd_mux = rx_over_count;
        end else if (hit_cpc) begin
            rd_mux = cell_ctl_q;
        end else if (hit_cps) begin
            rd_mux = cell_status;
        end
    end

    // ====================================================================
    // Writable control registers
    // Read-only words have no write enable here, so writes fall away.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            main_control_q <= cmit_pkg::RST_MAIN_CONTROL;
            page_q         <= cmit_pkg::RST_PAGE_WINDOW[4:0];
            memcfg_q       <= cmit_pkg::RST_MEMORY_CONFIG;
            tx_ctl_q       <= cmit_pkg::RST_ZERO;
            rx_ctl_q       <= cmit_pkg::RST_ZERO;
            cell_ctl_q     <= cmit_pkg::RST_ZERO;
        end else if (int_wr) begin // [R8] [R16]
            if (hit_mc) main_control_q <= host_wdata; // [R14]
            if (hit_pw) page_q <= host_wdata[4:0]; // [R3]
            if (hit_mem) memcfg_q <= host_wdata; // [R9]
            if (hit_txc) tx_ctl_q <= host_wdata; // [R10]
            if (hit_rxc) rx_ctl_q <= host_wdata; // [R10]
            if (hit_cpc) cell_ctl_q <= host_wdata; // [R10]
        end
    end

    // ====================================================================
    // Access sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            cmit_pkg::ST_IDLE: begin
                if (take_int) state_d = cmit_pkg::ST_INT;
                if (take_ext) state_d = cmit_pkg::ST_EXT;
            end
            cmit_pkg::ST_INT: begin
                state_d = cmit_pkg::ST_ANS;
            end
            cmit_pkg::ST_EXT: begin
                if (ext_ack) state_d = cmit_pkg::ST_ANS;
            end
            cmit_pkg::ST_ANS: begin
                state_d = cmit_pkg::ST_IDLE;
            end
            default: begin
                state_d = cmit_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= cmit_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Capture the internal read select at the taking edge.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_mux_q  <= cmit_pkg::RST_ZERO;
            sel_ram_q <= 1'b0;
        end else if (take_int) begin
            rd_mux_q  <= rd_mux;
            sel_ram_q <= ram_hit && reg_open;
        end
    end

    // ====================================================================
    // External window request; the page supplies the top address bits.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_req_q   <= 1'b0;
            ext_we_q    <= 1'b0;
            ext_rd_q    <= 1'b0;
            ext_addr_q  <= '0;
            ext_wdata_q <= cmit_pkg::RST_ZERO;
        end else begin
            ext_req_q <= take_ext; // [R2]
            if (take_ext) begin
                ext_we_q    <= host_wr;
                ext_rd_q    <= !host_wr;
                ext_addr_q  <= {page_q, host_addr}; // [R3] [R5]
                ext_wdata_q <= host_wdata;
            end
        end
    end

    // ====================================================================
    // Answer data and read parity of the last external read word
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q  <= cmit_pkg::RST_ZERO;
            parity_q <= cmit_pkg::RST_ZERO;
        end else if (state_q == cmit_pkg::ST_INT) begin
            rdata_q <= sel_ram_q ? ram_rdata : rd_mux_q;
        end else if (state_q == cmit_pkg::ST_EXT && ext_ack) begin
            rdata_q <= ext_rd_q ? ext_rdata : cmit_pkg::RST_ZERO;
            if (ext_rd_q) parity_q <= {15'h0000, ^ext_rdata};
        end
    end

    // ====================================================================
    // Outputs
    assign host_rdata         = rdata_q;
    assign host_ack           = state_q == cmit_pkg::ST_ANS;
    assign host_busy          = state_q != cmit_pkg::ST_IDLE;
    assign ext_req            = ext_req_q;
    assign ext_we             = ext_we_q;
    assign ext_addr           = ext_addr_q;
    assign ext_wdata          = ext_wdata_q;
    assign irq                = irq_q;
    assign soft_reset_release = main_control_q[cmit_pkg::SOFT_RESET_RELEASE_BIT]; // [R15]
    assign aal5_wo_bits       = memcfg_q & cmit_pkg::MEMORY_CONFIG_WO_MASK; // [R9]

endmodule : cmit_regmap

`default_nettype wire

// ---- dv/cmit_regmap_sva.sv ----
// Assertions on the host port of the register map and interrupt tree.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cmit_regmap_sva (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic host_req,
    input wire logic host_wr,
    input wire logic int_ext_space_select,
    input wire logic host_ack,
    input wire logic host_busy,
    input wire logic ext_req,
    input wire logic ext_ack,
    input wire logic soft_reset_release
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // An internal write taken this cycle; soft release may only follow it.
    wire logic int_wr = host_req && host_wr && !host_busy
                        && !int_ext_space_select;
    sequence s_take; host_req && !host_busy; endsequence
    sequence s_int; s_take ##0 !int_ext_space_select; endsequence
    AST_INT_ACK: assert property (s_int |-> ##2 host_ack)
        else $error("internal answer late");
    AST_INT_NO_EXT: assert property (s_int |=> !ext_req)
        else $error("internal access went out");
    AST_EXT_REQ: assert property (s_take
        ##0 int_ext_space_select |=> ext_req) else $error("no window request");
    AST_EXT_ACK: assert property (ext_ack && host_busy && !host_ack
        |=> host_ack) else $error("window answer lost");
    AST_EXT_ONE: assert property (ext_req |=> !ext_req)
        else $error("window request too long");
    AST_BUSY: assert property (s_int |=> host_busy[*2])
        else $error("not busy through access");
    AST_ACK_ONE: assert property (host_ack |=> !host_ack)
        else $error("answer strobe too long");
    AST_SOFT: assert property ($rose(soft_reset_release)
        |-> $past(int_wr)) else $error("soft release with no write");
endmodule : cmit_regmap_sva
bind cmit_regmap cmit_regmap_sva u_cmit_regmap_sva (.*);
`default_nettype wire

// ---- dv/cmit_sram_model.sv ----
// Behavioural external memory answering the window requests.
// Assumes one request at a time; slow stretches the answer delay.
`timescale 1ns/1ps
`default_nettype none
module cmit_sram_model (
    input  wire logic        core_clk,
    input  wire logic        slow,
    input  wire logic        ext_req,
    input  wire logic        ext_we,
    input  wire logic [19:0] ext_addr,
    input  wire logic [15:0] ext_wdata,
    output var  logic [15:0] ext_rdata = 16'h0000,
    output var  logic        ext_ack = 1'h0
);
    logic [15:0] mem [logic [19:0]];
    int          dly = 0;
    // Count down the answer; the data bus toggles when nothing is driven.
    always @(posedge core_clk) begin
        ext_ack <= 1'h0;
        ext_rdata <= ~ext_rdata;
        dly <= ext_req ? (slow ? 5 : 1) : dly - (dly > 0);
        if (dly == 1) begin
            ext_ack <= 1'h1;
            if (ext_we) mem[ext_addr] = ext_wdata;
            ext_rdata <= mem.exists(ext_addr) ? mem[ext_addr] : 16'h0000;
        end
    end
endmodule : cmit_sram_model
`default_nettype wire

// ---- dv/cmit_regmap_tb.sv ----
// Self-checking bench for the host register map and interrupt tree.
// Assumes the design, its checker and the external memory model.
`timescale 1ns/1ps
`default_nettype none
module cmit_regmap_tb;
    logic        core_clk = 1'h0, rst = 1'h1, host_req = 1'h0, slow = 1'h0;
    logic        host_wr = 1'h0, int_ext_space_select = 1'h0, irq;
    logic        tdm_pending = 1'h0, tim_pending = 1'h0, soft_reset_release;
    logic        host_ack, host_busy, ext_req, ext_we, ext_ack;
    logic [14:0] host_addr = 15'h0000;
    logic [19:0] ext_addr;
    logic [15:0] host_wdata = 16'h0000, host_rdata, ext_wdata, ext_rdata, rd;
    logic [15:0] tx_events = 16'h0000, rx_events = 16'h0000, aal5_wo_bits;
    logic [15:0] cell_events = 16'h0000, rx_misc_id = 16'h3C5A;
    logic [15:0] rx_misc_count = 16'h0000, rx_under_id = 16'h0000;
    logic [15:0] rx_under_count = 16'h0000, rx_over_id = 16'h0000;
    logic [15:0] rx_over_count = 16'h0000;
    int          mismatches = 0, cmp_count = 0, cyc = 0;
    cmit_regmap u_cmit_regmap (.*);
    cmit_sram_model u_cmit_sram_model (.*);
    // Free-running 40 MHz core clock.
    always #12.5 core_clk = ~core_clk;
    // Cuts a hang short; tests need about 110 cycles.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            final_report();
        end
    end
    // One word access; the request is a one-cycle pulse.
    task automatic acc(input logic s, w, input logic [15:0] a, d);
        @(negedge core_clk);
        {host_req, host_wr, int_ext_space_select} = {1'h1, w, s};
        host_addr = a[15:1];
        host_wdata = d;
        @(negedge core_clk);
        host_req = 1'h0;
        while (host_ack !== 1'h1) @(negedge core_clk);
        rd = host_rdata;
    endtask : acc
    task automatic chk(input logic [15:0] g, e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rc(input logic s, input logic [15:0] a, e);
        acc(s, 1'h0, a, 16'h0000);
        chk(rd, e);
    endtask : rc
    task automatic final_report();
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // Register accesses and expected answers.
    initial begin
        repeat (6) @(negedge core_clk);
        rst = 1'h0;
        rc(1'h0, 16'h0000, 16'h0000);
        rc(1'h0, 16'h0012, 16'h0001);
        acc(1'h0, 1'h1, 16'h2000, 16'hFFFF);
        acc(1'h0, 1'h1, 16'h0000, 16'h8000);
        rc(1'h0, 16'h2000, 16'h0000);
        acc(1'h0, 1'h1, 16'h2010, 16'hA5A5);
        rc(1'h0, 16'h2010, 16'hA5A5);
        acc(1'h0, 1'h1, 16'h0002, 16'hFFFF);
        rc(1'h0, 16'h0002, 16'h0000);
        acc(1'h0, 1'h1, 16'h0040, 16'hF008);
        rc(1'h0, 16'h0040, 16'h0008);
        chk(aal5_wo_bits, 16'hF000);
        tx_events = 16'h0009;
        repeat (2) @(negedge core_clk);
        tx_events = 16'h0001;
        rc(1'h0, 16'h2002, 16'h0009);
        acc(1'h0, 1'h1, 16'h2002, 16'h0000);
        rc(1'h0, 16'h2002, 16'h0009);
        acc(1'h0, 1'h1, 16'h2002, 16'hFFFF);
        rc(1'h0, 16'h2002, 16'h0001);
        {tdm_pending, tim_pending, rx_events, cell_events} = {2'h3, 32'h10001};
        for (int m = 2; m < 5; m++) acc(1'h0, 1'h1, 16'(m) << 12, 16'h0001);
        rc(1'h0, 16'h0002, 16'h001F);
        chk({15'h0000, irq}, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            acc(1'h0, 1'h1, 16'h0000, 16'h8000 | (16'h0001 << i));
            chk({15'h0000, irq}, 16'h0001);
        end
        acc(1'h0, 1'h1, 16'h0030, 16'hFFF3);
        rc(1'h0, 16'h0030, 16'h0013);
        acc(1'h1, 1'h1, 16'h1234, 16'hBEEF);
        chk(ext_addr[19:4], {5'h13, 11'h091});
        slow = 1'h1;
        rc(1'h1, 16'h1234, 16'hBEEF);
        rc(1'h0, 16'h0036, 16'h0001);
        rc(1'h0, 16'h1234, 16'h0000);
        final_report();
    end
endmodule : cmit_regmap_tb
`default_nettype wire
